// File: design/irqrt_ctrl.sv
// Interrupt response logic: pin sampling, flags, fixed polling, blocking
// conditions, in-service tracking and the six-cycle hardware call.
// Assumes the core sequencer reports instruction boundaries on clk_sys and
// that software reaches the registers over Avalon-MM.
import irqrt_pkg::*;

module irqrt_ctrl (
  // Clock and reset
  input  wire logic               clk_sys,
  input  wire logic               reset_n,
  // External request pins, active low
  input  wire logic [3:0]         ext_req_pin,
  // Timer overflow events, one-cycle pulses
  input  wire logic               timer_a_overflow,
  input  wire logic               timer_b_overflow,
  // Core sequencer status
  input  wire irqrt_pkg::irqrt_core_t core_status,
  // Hardware call towards the core
  output logic                    call_active,
  output irqrt_pkg::irqrt_call_t  call_out,
  // Avalon-MM slave
  input  wire logic [3:0]         avs_address,
  input  wire logic               avs_read,
  input  wire logic               avs_write,
  input  wire logic [31:0]        avs_writedata,
  output logic [31:0]             avs_readdata,
  output logic                    avs_waitrequest
);
  import irqrt_pkg::*;

  typedef enum logic [1:0] {
    IRQRT_IDLE = 2'b00,
    IRQRT_CALL = 2'b01,
    IRQRT_HOLD = 2'b10
  } irqrt_state_t;

  // Fixed vector per source
  function automatic logic [15:0] irqrt_vector(input logic [2:0] src);
    case (src)
      IRQRT_SRC_EXT_A: irqrt_vector = IRQRT_VEC_EXT_A;
      IRQRT_SRC_TMR_A: irqrt_vector = IRQRT_VEC_TMR_A;
      IRQRT_SRC_EXT_B: irqrt_vector = IRQRT_VEC_EXT_B;
      IRQRT_SRC_TMR_B: irqrt_vector = IRQRT_VEC_TMR_B;
      IRQRT_SRC_EXT_C: irqrt_vector = IRQRT_VEC_EXT_C;
      default:         irqrt_vector = IRQRT_VEC_EXT_D;
    endcase
  endfunction : irqrt_vector

  // Pin synchronisers and edge history
  logic [3:0] pin_s1_reg, pin_s1_next;
  logic [3:0] pin_s2_reg, pin_s2_next;
  logic [3:0] pin_prev_reg, pin_prev_next;
  // Flags
  logic [3:0] ext_flag_reg, ext_flag_next;
  logic       tmr_a_flag_reg, tmr_a_flag_next;
  logic       tmr_b_flag_reg, tmr_b_flag_next;
  // Registers
  logic [7:0] enable_reg, enable_next;
  logic [7:0] priority_reg, priority_next;
  logic [3:0] trig_reg, trig_next;
  // In service per level: bit 0 low, bit 1 high
  logic [1:0] inserv_reg, inserv_next;
  // Core side tracking
  logic       hold_one_reg, hold_one_next;
  irqrt_state_t state_reg, state_next;
  logic [2:0] cnt_reg, cnt_next;
  irqrt_call_t call_reg, call_next;
  logic       call_active_reg, call_active_next;
  logic [31:0] rdata_reg, rdata_next;
  logic       ack_reg, ack_next;
  logic       wait_reg, wait_next;

  // Pending sources and selection
  logic [IRQRT_NSRC-1:0] pend;
  logic [IRQRT_NSRC-1:0] en_src;
  logic [IRQRT_NSRC-1:0] prio_src;
  logic       found;
  logic [2:0] sel;
  logic       sel_hi;
  logic       blocked;
  logic       grant;
  logic       wr_acc;
  logic       rd_acc;
  logic [3:0] ext_level;

  always_comb begin
    en_src = {enable_reg[IRQRT_EN_EXT_D], enable_reg[IRQRT_EN_EXT_C],
              enable_reg[IRQRT_EN_TMR_B], enable_reg[IRQRT_EN_EXT_B],
              enable_reg[IRQRT_EN_TMR_A], enable_reg[IRQRT_EN_EXT_A]};
    prio_src = {priority_reg[IRQRT_EN_EXT_D], priority_reg[IRQRT_EN_EXT_C],
                priority_reg[IRQRT_EN_TMR_B], priority_reg[IRQRT_EN_EXT_B],
                priority_reg[IRQRT_EN_TMR_A], priority_reg[IRQRT_EN_EXT_A]};
    // Every flag counts only with its own enable bit and the global enable
    pend = {ext_flag_reg[3], ext_flag_reg[2], tmr_b_flag_reg,
            ext_flag_reg[1], tmr_a_flag_reg, ext_flag_reg[0]}
           & en_src & {IRQRT_NSRC{enable_reg[IRQRT_EN_GLOBAL]}};
    found  = 1'b0;
    sel    = IRQRT_SRC_EXT_A;
    sel_hi = 1'b0;
    // High level first, then fixed polling order within a level
    for (int i = IRQRT_NSRC - 1; i >= 0; i--) begin
      if (pend[i] && prio_src[i] && !inserv_reg[1]) begin
        found  = 1'b1;
        sel    = 3'(i);
        sel_hi = 1'b1;
      end
    end
    if (!found) begin
      for (int i = IRQRT_NSRC - 1; i >= 0; i--) begin
        if (pend[i] && !prio_src[i] && inserv_reg == 2'b00) begin
          found = 1'b1;
          sel   = 3'(i);
        end
      end
    end
    // Polling happens only on an instruction's last cycle
    blocked = !core_status.instr_last
              || core_status.instr_blocking
              || hold_one_reg
              || core_status.prog_busy;
    grant = found && !blocked && state_reg == IRQRT_IDLE;
  end

  assign wr_acc = avs_write && !ack_reg;
  assign rd_acc = avs_read && !ack_reg;

  always_comb begin
    // Two-stage synchroniser, inverted at the flag input
    pin_s1_next   = ext_req_pin;
    pin_s2_next   = pin_s1_reg;
    pin_prev_next = pin_s2_reg;
    ext_level     = ~pin_s2_reg;
    for (int i = 0; i < 4; i++) begin
      if (trig_reg[i]) begin
        ext_flag_next[i] = ext_flag_reg[i];
        if (grant && sel == 3'(i == 0 ? 0 : i == 1 ? 2 : i + 2)) begin
          ext_flag_next[i] = 1'b0;
        end
        // Falling edge sets; set wins over the vectoring clear
        if (pin_prev_reg[i] && !pin_s2_reg[i]) begin
          ext_flag_next[i] = 1'b1;
        end
      end else begin
        ext_flag_next[i] = ext_level[i];
      end
    end

    tmr_a_flag_next = tmr_a_flag_reg;
    tmr_b_flag_next = tmr_b_flag_reg;
    if (grant && sel == IRQRT_SRC_TMR_A) begin
      tmr_a_flag_next = 1'b0;
    end
    if (grant && sel == IRQRT_SRC_TMR_B) begin
      tmr_b_flag_next = 1'b0;
    end
    if (wr_acc && avs_address == IRQRT_OFF_CONTROL) begin
      if (avs_writedata[IRQRT_CTL_SET_TA]) begin
        tmr_a_flag_next = 1'b1;
      end
      if (avs_writedata[IRQRT_CTL_SET_TB]) begin
        tmr_b_flag_next = 1'b1;
      end
    end
    if (timer_a_overflow) begin
      tmr_a_flag_next = 1'b1;
    end
    if (timer_b_overflow) begin
      tmr_b_flag_next = 1'b1;
    end

    enable_next   = enable_reg;
    priority_next = priority_reg;
    trig_next     = trig_reg;
    if (wr_acc) begin
      case (avs_address)
        IRQRT_OFF_ENABLE:   enable_next = avs_writedata[7:0];
        IRQRT_OFF_PRIORITY: priority_next = avs_writedata[7:0];
        IRQRT_OFF_CONTROL:  trig_next = avs_writedata[3:0];
        default: ;
      endcase
    end

    ack_next   = (avs_read || avs_write) && !ack_reg;
    wait_next  = !ack_next;
    rdata_next = 32'h0000_0000;
    if (rd_acc) begin
      case (avs_address)
        IRQRT_OFF_ENABLE:   rdata_next = {24'h000000, enable_reg};
        IRQRT_OFF_PRIORITY: rdata_next = {24'h000000, priority_reg};
        IRQRT_OFF_CONTROL:  rdata_next = {22'h0, tmr_b_flag_reg,
                                          tmr_a_flag_reg, 4'h0, trig_reg};
        IRQRT_OFF_STATUS:   rdata_next = {16'h0000, 2'b00, inserv_reg,
                                          ext_flag_reg, 1'b0,
                                          call_reg.source, 3'h0,
                                          call_active_reg};
        default:            rdata_next = 32'h0000_0000;
      endcase
    end
  end

  always_comb begin
    state_next       = state_reg;
    cnt_next         = cnt_reg;
    call_next        = call_reg;
    call_active_next = call_active_reg;
    inserv_next      = inserv_reg;
    hold_one_next    = hold_one_reg;
    // Only the return-from-irq end marker clears a level
    if (core_status.return_from_irq_done) begin
      if (inserv_reg[1]) begin
        inserv_next[1] = 1'b0;
      end else begin
        inserv_next[0] = 1'b0;
      end
      hold_one_next = 1'b1;
    end else if (hold_one_reg && core_status.instr_last) begin
      hold_one_next = 1'b0;
    end
    case (state_reg)
      IRQRT_IDLE: begin
        if (grant) begin
          state_next       = IRQRT_CALL;
          cnt_next         = IRQRT_CALL_CYCLES;
          call_next.grant  = 1'b1;
          call_next.source = sel;
          call_next.vector = irqrt_vector(sel);
          call_active_next = 1'b1;
          if (sel_hi) begin
            inserv_next[1] = 1'b1;
          end else begin
            inserv_next[0] = 1'b1;
          end
        end
      end
      IRQRT_CALL: begin
        call_next.grant = 1'b0;
        if (cnt_reg == 3'h1) begin
          state_next       = IRQRT_HOLD;
          call_active_next = 1'b0;
        end
        cnt_next = cnt_reg - 3'h1;
      end
      IRQRT_HOLD: begin
        // One idle cycle so the core's first routine instruction starts
        state_next = IRQRT_IDLE;
      end
      default: begin
        state_next = IRQRT_IDLE;
      end
    endcase
  end

  always_ff @(posedge clk_sys or negedge reset_n) begin
    if (!reset_n) begin
      pin_s1_reg      <= 4'hf;
      pin_s2_reg      <= 4'hf;
      pin_prev_reg    <= 4'hf;
      ext_flag_reg    <= 4'h0;
      tmr_a_flag_reg  <= 1'b0;
      tmr_b_flag_reg  <= 1'b0;
      enable_reg      <= IRQRT_ENABLE_RST;
      priority_reg    <= IRQRT_PRIORITY_RST;
      trig_reg        <= IRQRT_TRIG_RST;
      inserv_reg      <= 2'b00;
      hold_one_reg    <= 1'b0;
      state_reg       <= IRQRT_IDLE;
      cnt_reg         <= 3'h0;
      call_reg        <= '0;
      call_active_reg <= 1'b0;
      rdata_reg       <= 32'h0000_0000;
      ack_reg         <= 1'b0;
      wait_reg        <= 1'b1;
    end else begin
      pin_s1_reg      <= pin_s1_next;
      pin_s2_reg      <= pin_s2_next;
      pin_prev_reg    <= pin_prev_next;
      ext_flag_reg    <= ext_flag_next;
      tmr_a_flag_reg  <= tmr_a_flag_next;
      tmr_b_flag_reg  <= tmr_b_flag_next;
      enable_reg      <= enable_next;
      priority_reg    <= priority_next;
      trig_reg        <= trig_next;
      inserv_reg      <= inserv_next;
      hold_one_reg    <= hold_one_next;
      state_reg       <= state_next;
      cnt_reg         <= cnt_next;
      call_reg        <= call_next;
      call_active_reg <= call_active_next;
      rdata_reg       <= rdata_next;
      ack_reg         <= ack_next;
      wait_reg        <= wait_next;
    end
  end

  assign call_active     = call_active_reg;
  assign call_out        = call_reg;
  assign avs_readdata    = rdata_reg;
  // Waitrequest high until the registered answer is ready
  assign avs_waitrequest = wait_reg;

endmodule : irqrt_ctrl

// File: common/irqrt_pkg.sv
// Package for the interrupt response timing block: register map, vectors,
// reset values and timing constants.
// Assumes a 32-bit Avalon-MM slave port and a 100 MHz system clock.
package irqrt_pkg;

  // Register word offsets (byte addresses)
  localparam logic [3:0] IRQRT_OFF_ENABLE   = 4'h0;
  localparam logic [3:0] IRQRT_OFF_PRIORITY = 4'h4;
  localparam logic [3:0] IRQRT_OFF_CONTROL  = 4'h8;
  localparam logic [3:0] IRQRT_OFF_STATUS   = 4'hc;

  // Enable register fields
  localparam int IRQRT_EN_EXT_A   = 0;
  localparam int IRQRT_EN_TMR_A   = 1;
  localparam int IRQRT_EN_EXT_B   = 2;
  localparam int IRQRT_EN_TMR_B   = 3;
  localparam int IRQRT_EN_EXT_C   = 4;
  localparam int IRQRT_EN_EXT_D   = 5;
  localparam int IRQRT_EN_GLOBAL  = 7;

  // Control register fields: trigger types and software flag set
  localparam int IRQRT_CTL_TRIG_A = 0;
  localparam int IRQRT_CTL_TRIG_B = 1;
  localparam int IRQRT_CTL_TRIG_C = 2;
  localparam int IRQRT_CTL_TRIG_D = 3;
  localparam int IRQRT_CTL_SET_TA = 8;
  localparam int IRQRT_CTL_SET_TB = 9;

  localparam logic [7:0] IRQRT_ENABLE_RST   = 8'h00;
  localparam logic [7:0] IRQRT_PRIORITY_RST = 8'h00;
  localparam logic [3:0] IRQRT_TRIG_RST     = 4'h0;

  // Source indices in fixed polling order
  localparam int IRQRT_NSRC = 6;
  localparam logic [2:0] IRQRT_SRC_EXT_A = 3'h0;
  localparam logic [2:0] IRQRT_SRC_TMR_A = 3'h1;
  localparam logic [2:0] IRQRT_SRC_EXT_B = 3'h2;
  localparam logic [2:0] IRQRT_SRC_TMR_B = 3'h3;
  localparam logic [2:0] IRQRT_SRC_EXT_C = 3'h4;
  localparam logic [2:0] IRQRT_SRC_EXT_D = 3'h5;

  // Vector addresses
  localparam logic [15:0] IRQRT_VEC_EXT_A = 16'h0003;
  localparam logic [15:0] IRQRT_VEC_TMR_A = 16'h000b;
  localparam logic [15:0] IRQRT_VEC_EXT_B = 16'h0013;
  localparam logic [15:0] IRQRT_VEC_TMR_B = 16'h001b;
  localparam logic [15:0] IRQRT_VEC_EXT_C = 16'h0033;
  localparam logic [15:0] IRQRT_VEC_EXT_D = 16'h003b;

  // Hardware call length in system clocks
  localparam logic [2:0] IRQRT_CALL_CYCLES = 3'h6;

  typedef struct packed {
    logic        grant;
    logic [15:0] vector;
    logic [2:0]  source;
  } irqrt_call_t;

  typedef struct packed {
    logic instr_last;
    logic instr_blocking;
    logic return_from_irq_done;
    logic prog_busy;
  } irqrt_core_t;

endpackage : irqrt_pkg

// File: dv/irqrt_ctrl_asserts.sv
// Checker: call timing, vector map and bus handshake of irqrt_ctrl.
// Sees only the top module's ports; bound after the module.
module irqrt_ctrl_asserts (
  // Clock and reset
  input wire logic                   clk_sys,
  input wire logic                   reset_n,
  // Core and call
  input wire irqrt_pkg::irqrt_core_t core_status,
  input wire logic                   call_active,
  input wire irqrt_pkg::irqrt_call_t call_out,
  // Bus
  input wire logic                   avs_read,
  input wire logic                   avs_write,
  input wire logic                   avs_waitrequest
);
  timeunit 1ns;
  timeprecision 1ps;
  import irqrt_pkg::*;
  logic [2:0] src_map;

  // Pins c and d sit two vector slots above their poll index
  assign src_map = (call_out.source > 3'h3) ? call_out.source + 3'h2
                                            : call_out.source;

  default clocking cb @(posedge clk_sys); endclocking
  default disable iff (!reset_n);

  call_len_a: assert property (
    $rose(call_active) |-> call_active [*6] ##1 !call_active)
    else $error("call length is not six cycles");
  call_gap_a: assert property (
    $fell(call_active) |-> !call_active [*2])
    else $error("calls merged without a gap");
  grant_start_a: assert property (
    $rose(call_active) |-> call_out.grant ##1 !call_out.grant)
    else $error("grant not a single pulse at call start");
  take_last_a: assert property (
    $rose(call_active) |-> $past(core_status.instr_last))
    else $error("call taken mid instruction");
  take_block_a: assert property (
    $rose(call_active) |-> !$past(core_status.instr_blocking))
    else $error("call taken after blocking instruction");
  prog_block_a: assert property (
    core_status.prog_busy |=> !call_out.grant)
    else $error("call during code programming");
  return_from_irq_hold_a: assert property (
    core_status.return_from_irq_done |=> !call_out.grant [*2])
    else $error("call right after return");
  vec_map_a: assert property (
    call_out.grant |-> call_out.vector == {10'h0, src_map, 3'h3})
    else $error("vector does not match source");
  bus_ack_a: assert property (
    $rose(avs_read || avs_write) |=> !avs_waitrequest ##1 avs_waitrequest)
    else $error("bus answer not one cycle after request");
endmodule : irqrt_ctrl_asserts

bind irqrt_ctrl irqrt_ctrl_asserts u_irqrt_ctrl_asserts (
  .clk_sys(clk_sys), .reset_n(reset_n), .core_status(core_status),
  .call_active(call_active), .call_out(call_out),
  .avs_read(avs_read), .avs_write(avs_write),
  .avs_waitrequest(avs_waitrequest));

// File: dv/irqrt_core_model.sv
// Core sequencer model: fixed-length instructions, idle during a call,
// a return instruction on request from the bench.
// Assumes instr_len stays between 2 and 7 while out of reset.
module irqrt_core_model (
  // Clock and reset
  input  wire logic              clk_sys,
  input  wire logic              reset_n,
  // Bench controls
  input  wire logic [2:0]        instr_len,
  input  wire logic              return_from_irq_req,
  input  wire logic              prog_req,
  // Design side
  input  wire logic              call_active,
  output irqrt_pkg::irqrt_core_t core_status
);
  timeunit 1ns;
  timeprecision 1ps;
  import irqrt_pkg::*;
  logic [2:0] cnt_reg, cnt_next;
  logic       return_from_irq_reg, return_from_irq_next;
  logic       last;

  always_comb begin
    last = (cnt_reg == instr_len - 3'h1) && !call_active;
    cnt_next = (last || call_active) ? 3'h0 : cnt_reg + 3'h1;
    // The return stays the current instruction until its last cycle
    return_from_irq_next = (return_from_irq_reg && !last) || return_from_irq_req;
    core_status.instr_last = last;
    core_status.instr_blocking = return_from_irq_reg;
    core_status.return_from_irq_done = return_from_irq_reg && last;
    core_status.prog_busy = prog_req;
  end

  always_ff @(posedge clk_sys or negedge reset_n) begin
    if (!reset_n) begin
      cnt_reg <= 3'h0;
      return_from_irq_reg <= 1'b0;
    end else begin
      cnt_reg <= cnt_next;
      return_from_irq_reg <= return_from_irq_next;
    end
  end
endmodule : irqrt_core_model

// File: dv/irqrt_ctrl_tb.sv
// Bench for irqrt_ctrl: registers, level and edge requests, timer order.
// Assumes the core model runs 3-cycle instructions.
module irqrt_ctrl_tb;
  timeunit 1ns;
  timeprecision 1ps;
  import irqrt_pkg::*;
  logic        clk_sys, reset_n, timer_a_overflow, timer_b_overflow;
  logic        call_active, avs_read, avs_write, avs_waitrequest;
  logic        return_from_irq_req, prog_req;
  logic [2:0]  instr_len;
  logic [3:0]  ext_req_pin, avs_address;
  logic [31:0] avs_writedata, avs_readdata, q;
  irqrt_core_t core_status;
  irqrt_call_t call_out;
  int          mismatches, checked, n;

  irqrt_ctrl u_irqrt_ctrl (.clk_sys(clk_sys), .reset_n(reset_n),
    .ext_req_pin(ext_req_pin), .timer_a_overflow(timer_a_overflow),
    .timer_b_overflow(timer_b_overflow), .core_status(core_status),
    .call_active(call_active), .call_out(call_out),
    .avs_address(avs_address), .avs_read(avs_read),
    .avs_write(avs_write), .avs_writedata(avs_writedata),
    .avs_readdata(avs_readdata), .avs_waitrequest(avs_waitrequest));
  irqrt_core_model u_irqrt_core_model (.clk_sys(clk_sys),
    .reset_n(reset_n), .instr_len(instr_len), .return_from_irq_req(return_from_irq_req),
    .prog_req(prog_req), .call_active(call_active),
    .core_status(core_status));

  initial begin
    clk_sys = 1'b0;
    forever #5 clk_sys = ~clk_sys;
  end

  task automatic results();
    $display("checked %0d mismatches %0d", checked, mismatches);
    if (mismatches == 0 && checked > 0)
      $display("bench passed");
    else
      $display("bench failed");
    $finish;
  endtask : results

  task automatic cmp_val(input logic [31:0] got, input logic [31:0] exp);
    checked++;
    if (got !== exp) begin
      mismatches++;
      $display("unexpected at %0t: got %h expected %h", $time, got, exp);
    end
  endtask : cmp_val

  task automatic cmp_flag(input logic got, input logic exp);
    checked++;
    if (got !== exp) begin
      mismatches++;
      $display("unexpected at %0t: got %h expected %h", $time, got, exp);
    end
  endtask : cmp_flag

  task automatic stall();
    cmp_flag(1'b0, 1'b1);
    results();
  endtask : stall

  // Request held until waitrequest is seen low at a rising edge
  task automatic bus(input logic wr, input logic [3:0] a,
                     input logic [31:0] d, output logic [31:0] rd);
    int k;
    k = 0;
    @(posedge clk_sys);
    avs_address <= a;
    avs_write <= wr;
    avs_read <= !wr;
    avs_writedata <= d;
    do begin
      @(posedge clk_sys);
      k++;
    end while (avs_waitrequest !== 1'b0 && k < 20);
    rd = avs_readdata;
    avs_write <= 1'b0;
    avs_read <= 1'b0;
    if (avs_waitrequest !== 1'b0) stall();
  endtask : bus

  task automatic expect_call(input logic [15:0] vec);
    n = 0;
    do begin
      @(posedge clk_sys);
      n++;
    end while (call_out.grant !== 1'b1 && n < 60);
    if (call_out.grant !== 1'b1) stall();
    cmp_val({16'h0, call_out.vector}, {16'h0, vec});
  endtask : expect_call

  task automatic quiet(input int c);
    logic seen;
    seen = 1'b0;
    repeat (c) begin
      @(posedge clk_sys);
      if (call_out.grant === 1'b1) seen = 1'b1;
    end
    cmp_flag(seen, 1'b0);
  endtask : quiet

  task automatic return_from_irq();
    @(posedge clk_sys);
    return_from_irq_req <= 1'b1;
    @(posedge clk_sys);
    return_from_irq_req <= 1'b0;
  endtask : return_from_irq

  task automatic t_regs();
    bus(1'b0, IRQRT_OFF_ENABLE, 32'h0, q);
    cmp_val(q, {24'h0, IRQRT_ENABLE_RST});
    bus(1'b0, IRQRT_OFF_PRIORITY, 32'h0, q);
    cmp_val(q, {24'h0, IRQRT_PRIORITY_RST});
    bus(1'b0, 4'h2, 32'h0, q);
    cmp_val(q, 32'h0);
    bus(1'b1, IRQRT_OFF_ENABLE, 32'h81, q);
    bus(1'b0, IRQRT_OFF_ENABLE, 32'h0, q);
    cmp_val(q, (32'h1 << IRQRT_EN_GLOBAL) |
            (32'h1 << IRQRT_EN_EXT_A));
  endtask : t_regs

  task automatic t_level();
    @(posedge clk_sys);
    ext_req_pin <= 4'he;
    expect_call(IRQRT_VEC_EXT_A);
    // Counted from the pin change, through two sync stages and the flag latch
    cmp_flag((n + 4 > 7) && (n + 4 < 12), 1'b1);
    quiet(30);
    ext_req_pin <= 4'hf;
    quiet(5);
    return_from_irq();
    quiet(20);
  endtask : t_level

  task automatic t_edge();
    bus(1'b1, IRQRT_OFF_CONTROL, 32'h1, q);
    prog_req <= 1'b1;
    ext_req_pin <= 4'he;
    repeat (4) @(posedge clk_sys);
    ext_req_pin <= 4'hf;
    quiet(6);
    prog_req <= 1'b0;
    expect_call(IRQRT_VEC_EXT_A);
    return_from_irq();
    quiet(20);
  endtask : t_edge

  task automatic t_timers();
    bus(1'b1, IRQRT_OFF_CONTROL, 32'h300, q);
    quiet(20);
    bus(1'b0, IRQRT_OFF_CONTROL, 32'h0, q);
    cmp_val(q, 32'h300);
    bus(1'b1, IRQRT_OFF_ENABLE, 32'h8b, q);
    expect_call(IRQRT_VEC_TMR_A);
    return_from_irq();
    expect_call(IRQRT_VEC_TMR_B);
    return_from_irq();
    @(posedge clk_sys);
    timer_a_overflow <= 1'b1;
    @(posedge clk_sys);
    timer_a_overflow <= 1'b0;
    expect_call(IRQRT_VEC_TMR_A);
    return_from_irq();
    // Timer b on the high level overtakes the fixed order
    bus(1'b1, IRQRT_OFF_PRIORITY, 32'h08, q);
    bus(1'b1, IRQRT_OFF_CONTROL, 32'h300, q);
    expect_call(IRQRT_VEC_TMR_B);
    bus(1'b0, IRQRT_OFF_STATUS, 32'h0, q);
    cmp_val(q, 32'h2000 | {25'h0, IRQRT_SRC_TMR_B, 4'h1});
    return_from_irq();
    expect_call(IRQRT_VEC_TMR_A);
    return_from_irq();
    quiet(10);
  endtask : t_timers

  initial begin
    {reset_n, timer_a_overflow, timer_b_overflow} = 3'h0;
    {avs_read, avs_write, return_from_irq_req, prog_req} = 4'h0;
    avs_address = 4'h0;
    avs_writedata = 32'h0;
    ext_req_pin = 4'hf;
    instr_len = 3'h3;
    mismatches = 0;
    checked = 0;
    repeat (5) @(posedge clk_sys);
    reset_n <= 1'b1;
    t_regs();
    t_level();
    t_edge();
    t_timers();
    results();
  end
endmodule : irqrt_ctrl_tb
